//--- cst_ctrl.sv
// Confirmed-status task controller: per-tag interlock, restart, attention, mode page.
`timescale 1ns/1ps
module cst_ctrl #(
  parameter int ALERT_CYC = cst_pkg::ALERT_CYCLES,
  parameter int TAGS = 1 << cst_pkg::TAG_W,
  parameter int INITS = 1 << cst_pkg::INIT_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // Incoming command message.
  input wire logic i_cmd_valid,
  input wire logic [cst_pkg::TAG_W-1:0] i_cmd_tag,
  input wire logic [cst_pkg::PATH_W-1:0] i_cmd_logical_path_id,
  input wire logic i_cmd_confirm,
  input wire logic i_cmd_write,
  // Task engine reports a task done and wants to send status.
  input wire logic i_done_valid,
  input wire logic [cst_pkg::TAG_W-1:0] i_done_tag,
  // Task engine asks to begin a new data burst.
  input wire logic i_burst_req,
  input wire logic [cst_pkg::TAG_W-1:0] i_burst_tag,
  // Incoming confirm-status message.
  input wire logic i_conf_valid,
  input wire logic [cst_pkg::TAG_W-1:0] i_conf_tag,
  input wire logic i_conf_complete,
  input wire logic [cst_pkg::OFS_W-1:0] i_conf_offset,
  input wire logic [cst_pkg::PATH_W-1:0] i_conf_replacement_path_id,
  // Incoming data frame or message of a task, checked for staleness.
  input wire logic i_frame_valid,
  input wire logic [cst_pkg::TAG_W-1:0] i_frame_tag,
  input wire logic [cst_pkg::PATH_W-1:0] i_frame_logical_path_id,
  // Query-node message.
  input wire logic i_query_valid,
  input wire logic i_query_direction_bit,
  input wire logic [cst_pkg::PATH_W-1:0] i_query_logical_path_id,
  input wire logic [cst_pkg::INIT_W-1:0] i_query_init,
  input wire logic i_query_port,
  // Unit attention event, with optional causing initiator.
  input wire logic i_ua_event,
  input wire logic i_ua_by_msg,
  input wire logic [cst_pkg::INIT_W-1:0] i_ua_cause_init,
  input wire logic i_auto_hold_error_state,
  // Register bus.
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Outgoing message.
  output logic [2:0] o_tx_kind,
  output logic [cst_pkg::TAG_W-1:0] o_tx_tag,
  output logic [cst_pkg::PATH_W-1:0] o_tx_path,
  output logic [cst_pkg::OFS_W-1:0] o_tx_offset,
  output logic o_burst_grant,
  output logic o_frame_accept,
  output logic o_frame_drop,
  output logic o_sense_valid
);
  // ****************************************
  // Per-tag slot state
  // ****************************************
  cst_pkg::slot_state_t st_r [TAGS];
  logic [TAGS-1:0] conf_r;
  logic [TAGS-1:0] wr_r;
  logic [cst_pkg::PATH_W-1:0] path_r [TAGS];
  logic [31:0] tmo_r [TAGS];
  logic [TAGS-1:0] expire;
  // Initiator table: path to initiator map, port and per-initiator attention flags.
  logic [INITS-1:0] ua_r;
  logic [INITS-1:0] init_known;
  logic [cst_pkg::INIT_W-1:0] p2i_r [1 << cst_pkg::PATH_W];
  logic [(1 << cst_pkg::PATH_W)-1:0] pvalid_r;
  logic [(1 << cst_pkg::PATH_W)-1:0] pport_r;
  logic hold_r;
  logic [7:0] page_r [cst_pkg::PAGE_BYTES];

  wire hold = i_auto_hold_error_state | hold_r;
  wire [cst_pkg::INIT_W-1:0] cmd_init = p2i_r[i_cmd_logical_path_id];
  wire cmd_ua = i_cmd_valid && pvalid_r[i_cmd_logical_path_id] && ua_r[cmd_init];
  wire conf_live = i_conf_valid && st_r[i_conf_tag] != cst_pkg::SLOT_IDLE;
  wire conf_ok = conf_live && i_conf_complete && st_r[i_conf_tag] == cst_pkg::SLOT_WAIT;
  wire conf_restart = conf_live && !i_conf_complete;
  wire done_ok = i_done_valid && st_r[i_done_tag] == cst_pkg::SLOT_RUN && !hold;
  wire burst_ok = i_burst_req && st_r[i_burst_tag] == cst_pkg::SLOT_RUN && !hold;
  // Stale frames carry the path the task had before it was moved.
  wire frame_ok = i_frame_valid && st_r[i_frame_tag] != cst_pkg::SLOT_IDLE
    && path_r[i_frame_tag] == i_frame_logical_path_id;
  wire [cst_pkg::TAG_W-1:0] exp_tag;
  wire exp_any = |expire;

  // Lowest-numbered expired timer is reported first.
  function automatic logic [cst_pkg::TAG_W-1:0] first_set(input logic [TAGS-1:0] v);
    first_set = '0;
    for (int k = TAGS - 1; k >= 0; k--)
      if (v[k])
        first_set = k[cst_pkg::TAG_W-1:0];
  endfunction
  assign exp_tag = first_set(expire);

  // ****************************************
  // Slot machines and confirm timers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < TAGS; g++)
    begin : g_slot
      assign expire[g] = st_r[g] == cst_pkg::SLOT_WAIT && conf_r[g]
        && tmo_r[g] == ALERT_CYC[31:0] - 32'h1;
      // Command opens a slot unless its initiator has an attention flag set; confirm with complete set frees it.
      always_ff @(posedge i_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          st_r[g] <= cst_pkg::SLOT_IDLE;
          conf_r[g] <= 1'b0;
          wr_r[g] <= 1'b0;
          path_r[g] <= '0;
          tmo_r[g] <= 32'h0;
        end
        else if (i_cmd_valid && i_cmd_tag == g)
        begin
          st_r[g] <= cmd_ua ? cst_pkg::SLOT_IDLE : cst_pkg::SLOT_RUN;
          conf_r[g] <= i_cmd_confirm;
          wr_r[g] <= i_cmd_write;
          path_r[g] <= i_cmd_logical_path_id;
          tmo_r[g] <= 32'h0;
        end
        else if (conf_restart && i_conf_tag == g)
        begin
          st_r[g] <= cst_pkg::SLOT_RUN;
          path_r[g] <= i_conf_replacement_path_id;
          tmo_r[g] <= 32'h0;
        end
        else if (conf_ok && i_conf_tag == g)
          st_r[g] <= cst_pkg::SLOT_IDLE;
        else if (done_ok && i_done_tag == g)
        begin
          st_r[g] <= conf_r[g] ? cst_pkg::SLOT_WAIT : cst_pkg::SLOT_IDLE;
          tmo_r[g] <= 32'h0;
        end
        else if (expire[g])
          tmo_r[g] <= (exp_tag == g) ? 32'h0 : tmo_r[g];
        else if (st_r[g] == cst_pkg::SLOT_WAIT)
          tmo_r[g] <= tmo_r[g] + 32'h1;
      end
    end
  endgenerate

  // ****************************************
  // Initiator table and attention flags
  // ****************************************
  // An initiator is known once any of its paths has a table entry. An event that
  // comes before an initiator's first query is not presented to it later.
  always_comb
  begin
    init_known = '0;
    for (int k = 0; k < (1 << cst_pkg::PATH_W); k++)
      if (pvalid_r[k])
        init_known[p2i_r[k]] = 1'b1;
  end

  generate
    for (g = 0; g < INITS; g++)
    begin : g_ua
      // A new event wins over a clear in the same cycle.
      always_ff @(posedge i_clk or posedge i_rst)
      begin
        if (i_rst)
          ua_r[g] <= 1'b0;
        else if (i_ua_event && init_known[g] && !(i_ua_by_msg && i_ua_cause_init == g))
          ua_r[g] <= 1'b1;
        else if (cmd_ua && cmd_init == g)
          ua_r[g] <= 1'b0;
      end
    end
  endgenerate

  // Path entries are built from query-node messages heading outward.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pvalid_r <= '0;
      pport_r <= '0;
      for (int k = 0; k < (1 << cst_pkg::PATH_W); k++)
        p2i_r[k] <= '0;
    end
    else if (i_query_valid && !i_query_direction_bit)
    begin
      pvalid_r[i_query_logical_path_id] <= 1'b1;
      pport_r[i_query_logical_path_id] <= i_query_port;
      p2i_r[i_query_logical_path_id] <= i_query_init;
    end
  end

  // ****************************************
  // Outgoing message selection
  // ****************************************
  // Priority: check condition, restart, alert, status. Status is only sent
  // when no higher-priority message claims the port this cycle.
  logic [2:0] kind_nxt;
  logic [cst_pkg::TAG_W-1:0] tag_nxt;
  logic [cst_pkg::PATH_W-1:0] path_nxt;
  always_comb
  begin
    kind_nxt = cst_pkg::TX_NONE;
    tag_nxt = '0;
    path_nxt = '0;
    if (cmd_ua)
    begin
      kind_nxt = cst_pkg::TX_CHECK;
      tag_nxt = i_cmd_tag;
      path_nxt = i_cmd_logical_path_id;
    end
    else if (conf_restart)
    begin
      kind_nxt = wr_r[i_conf_tag] ? cst_pkg::TX_DATA_REQ : cst_pkg::TX_DATA_RDY;
      tag_nxt = i_conf_tag;
      path_nxt = i_conf_replacement_path_id;
    end
    else if (exp_any)
    begin
      kind_nxt = cst_pkg::TX_ALERT;
      tag_nxt = exp_tag;
      path_nxt = path_r[exp_tag];
    end
    else if (done_ok)
    begin
      kind_nxt = cst_pkg::TX_STATUS;
      tag_nxt = i_done_tag;
      path_nxt = path_r[i_done_tag];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_tx_kind <= cst_pkg::TX_NONE;
      o_tx_tag <= '0;
      o_tx_path <= '0;
      o_tx_offset <= '0;
      o_burst_grant <= 1'b0;
      o_frame_accept <= 1'b0;
      o_frame_drop <= 1'b0;
      o_sense_valid <= 1'b0;
    end
    else
    begin
      o_tx_kind <= kind_nxt;
      o_tx_tag <= tag_nxt;
      o_tx_path <= path_nxt;
      o_tx_offset <= (!cmd_ua && conf_restart) ? i_conf_offset : '0;
      o_burst_grant <= burst_ok;
      o_frame_accept <= frame_ok;
      o_frame_drop <= i_frame_valid && !frame_ok;
      o_sense_valid <= cmd_ua;
    end
  end

  // ****************************************
  // Register bus
  // ****************************************
  // Page bytes are stored and read back over the bus only; no other logic in the block uses them.
  wire page_hit = i_addr >= cst_pkg::REG_PAGE_BASE
    && i_addr < cst_pkg::REG_PAGE_BASE + 8'(4 * cst_pkg::PAGE_BYTES);
  wire [3:0] page_idx = 4'(((i_addr - cst_pkg::REG_PAGE_BASE) >> 2));
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hold_r <= 1'b0;
      for (int k = 0; k < cst_pkg::PAGE_BYTES; k++)
        page_r[k] <= cst_pkg::PAGE_RESET;
    end
    else if (i_wr)
    begin
      if (i_addr == cst_pkg::REG_CTRL)
        hold_r <= i_wdata[cst_pkg::CTRL_HOLD_BIT];
      if (page_hit)
        page_r[page_idx] <= i_wdata[7:0];
    end
  end

  logic [31:0] rd_nxt;
  logic [TAGS-1:0] waitv;
  always_comb
  begin
    for (int k = 0; k < TAGS; k++)
      waitv[k] = st_r[k] == cst_pkg::SLOT_WAIT;
    rd_nxt = 32'h0;
    if (i_addr == cst_pkg::REG_CTRL)
      rd_nxt = {31'h0, hold_r};
    else if (i_addr == cst_pkg::REG_STATUS)
      rd_nxt = 32'(waitv);
    else if (i_addr == cst_pkg::REG_UA_FLAGS)
      rd_nxt = 32'(ua_r);
    else if (page_hit)
      rd_nxt = {24'h0, page_r[page_idx]};
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= 32'h0;
    else
      o_rdata <= i_rd ? rd_nxt : 32'h0;
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence restart_in_s;
    i_conf_valid && !i_conf_complete && st_r[i_conf_tag] != cst_pkg::SLOT_IDLE && !cmd_ua;
  endsequence
  restart_msg_a: assert property (@(posedge i_clk) disable iff (i_rst)
    restart_in_s |=> (o_tx_kind == cst_pkg::TX_DATA_REQ || o_tx_kind == cst_pkg::TX_DATA_RDY)
      && o_tx_offset == $past(i_conf_offset) && o_tx_path == $past(i_conf_replacement_path_id))
    else $error("Restart did not send a data message on the new path.");
  hold_burst_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_auto_hold_error_state |=> !o_burst_grant && o_tx_kind != cst_pkg::TX_STATUS)
    else $error("Burst or status sent during the hold state.");
  ua_check_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cmd_ua |=> o_tx_kind == cst_pkg::TX_CHECK && o_sense_valid ##1 !ua_r[$past(cmd_init, 2)]
      || $past(i_ua_event) || $past(i_ua_event, 2))
    else $error("Attention command not ended with check condition.");
  ua_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ua_event && i_ua_by_msg && !(cmd_ua && cmd_init != i_ua_cause_init)
      && !ua_r[i_ua_cause_init] |=> !ua_r[$past(i_ua_cause_init)])
    else $error("Causing initiator got an attention flag.");
  ua_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ua_event && !i_ua_by_msg |=> (ua_r & $past(init_known)) == $past(init_known))
    else $error("Attention flags not set for all initiators.");
  stale_drop_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_frame_valid && path_r[i_frame_tag] != i_frame_logical_path_id |=> o_frame_drop)
    else $error("Stale frame was not dropped.");
  conf_free_a: assert property (@(posedge i_clk) disable iff (i_rst)
    conf_ok && !i_cmd_valid |=> st_r[$past(i_conf_tag)] == cst_pkg::SLOT_IDLE)
    else $error("Confirmed slot was not released.");
  query_entry_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_query_valid && !i_query_direction_bit |=> pvalid_r[$past(i_query_logical_path_id)])
    else $error("Query node did not create a table entry.");
  tmo_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
    exp_any && !cmd_ua && !conf_restart |=> o_tx_kind == cst_pkg::TX_ALERT)
    else $error("Expired confirm timer raised no alert.");
endmodule

//--- cst_pkg.sv
// Package of constants and types for the confirmed-status task controller.
package cst_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int ALERT_TIME_S = 5;
  localparam int ALERT_CYCLES = ALERT_TIME_S * CLK_HZ;
  localparam int TAG_W = 4;
  localparam int PATH_W = 4;
  localparam int INIT_W = 3;
  localparam int OFS_W = 32;
  localparam int PAGE_BYTES = 16;
  // Register bus offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_UA_FLAGS = 8'h08;
  localparam logic [7:0] REG_PAGE_BASE = 8'h40;
  localparam int CTRL_HOLD_BIT = 0;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  // Outgoing message kinds.
  localparam logic [2:0] TX_NONE = 3'h0;
  localparam logic [2:0] TX_STATUS = 3'h1;
  localparam logic [2:0] TX_ALERT = 3'h2;
  localparam logic [2:0] TX_DATA_REQ = 3'h3;
  localparam logic [2:0] TX_DATA_RDY = 3'h4;
  localparam logic [2:0] TX_CHECK = 3'h5;
  typedef enum logic [1:0] {
    SLOT_IDLE = 2'b00,
    SLOT_RUN = 2'b01,
    SLOT_WAIT = 2'b11,
    SLOT_HELD = 2'b10
  } slot_state_t;
endpackage

//--- initiator_model.sv
// Behavioural initiator that answers status and alert messages with confirms.
`timescale 1ns/1ps
module initiator_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_mode,
  input wire logic [3:0] i_delay,
  input wire logic [31:0] i_ofs,
  input wire logic [3:0] i_path,
  input wire logic [2:0] i_tx_kind,
  input wire logic [3:0] i_tx_tag,
  output logic o_valid,
  output logic [3:0] o_tag,
  output logic o_complete,
  output logic [31:0] o_offset,
  output logic [3:0] o_path
);
  logic pend_r;
  logic fin_r;
  logic [3:0] cnt_r;
  logic [3:0] tag_r;
  wire logic hit;
  // Mode 0 confirms each status; modes 1 and 2 act as if status was lost.
  assign hit = (i_mode == 2'h0) ? (i_tx_kind == cst_pkg::TX_STATUS) :
    (i_tx_kind == cst_pkg::TX_ALERT);
  // Idle lines show the inverse of their last value, so a stale sample is caught.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      {pend_r, fin_r, cnt_r, tag_r} <= '0;
      {o_valid, o_tag, o_complete, o_offset, o_path} <= '0;
    end
    else
    begin
      o_valid <= 1'b0;
      {o_tag, o_complete, o_offset, o_path} <= ~{o_tag, o_complete, o_offset, o_path};
      if (pend_r && cnt_r == 4'h0)
      begin
        pend_r <= 1'b0;
        o_valid <= 1'b1;
        {o_tag, o_complete, o_offset, o_path} <= {tag_r, fin_r, i_ofs, i_path};
      end
      else if (pend_r)
        cnt_r <= cnt_r - 4'h1;
      if (hit)
      begin
        {pend_r, cnt_r, tag_r} <= {1'b1, i_delay, i_tx_tag};
        fin_r <= (i_mode != 2'h2);
      end
    end
  end
endmodule

//--- test_confirmed_status_task_control.sv
// Self-checking testbench for the confirmed-status task controller.
`timescale 1ns/1ps
module test_confirmed_status_task_control;
  localparam int ALERT_C = 20;
  logic i_clk = 1'b0, i_rst = 1'b1, i_cmd_valid = 1'b0, i_cmd_confirm = 1'b0;
  logic i_cmd_write = 1'b0, i_done_valid = 1'b0, i_burst_req = 1'b0, i_frame_valid = 1'b0;
  logic i_query_valid = 1'b0, i_query_direction_bit = 1'b0, i_query_port = 1'b0;
  logic i_ua_event = 1'b0, i_ua_by_msg = 1'b0, i_auto_hold_error_state = 1'b0;
  logic i_wr = 1'b0, i_rd = 1'b0, i_conf_valid, i_conf_complete, o_burst_grant;
  logic o_frame_accept, o_frame_drop, o_sense_valid;
  logic [3:0] i_cmd_tag = 4'h0, i_cmd_logical_path_id = 4'h0, i_done_tag = 4'h0;
  logic [3:0] i_burst_tag = 4'h0, i_frame_tag = 4'h0, i_frame_logical_path_id = 4'h0;
  logic [3:0] i_query_logical_path_id = 4'h0, i_conf_tag, i_conf_replacement_path_id;
  logic [3:0] o_tx_tag, o_tx_path, delay = 4'h0, new_path = 4'h0;
  logic [2:0] i_query_init = 3'h0, i_ua_cause_init = 3'h0, o_tx_kind;
  logic [1:0] mode = 2'h0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, i_conf_offset, o_rdata, o_tx_offset, new_ofs = 32'h0;
  int bad_count = 0, comparisons = 0;
  cst_ctrl #(.ALERT_CYC(ALERT_C)) i_cst_ctrl (
    .i_clk, .i_rst, .i_cmd_valid, .i_cmd_tag, .i_cmd_logical_path_id, .i_cmd_confirm,
    .i_cmd_write, .i_done_valid, .i_done_tag, .i_burst_req, .i_burst_tag, .i_conf_valid,
    .i_conf_tag, .i_conf_complete, .i_conf_offset, .i_conf_replacement_path_id,
    .i_frame_valid, .i_frame_tag, .i_frame_logical_path_id, .i_query_valid,
    .i_query_direction_bit, .i_query_logical_path_id, .i_query_init, .i_query_port,
    .i_ua_event, .i_ua_by_msg, .i_ua_cause_init, .i_auto_hold_error_state, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .o_tx_kind, .o_tx_tag, .o_tx_path, .o_tx_offset,
    .o_burst_grant, .o_frame_accept, .o_frame_drop, .o_sense_valid
  );
  initiator_model i_initiator_model (
    .i_clk, .i_rst, .i_mode(mode), .i_delay(delay), .i_ofs(new_ofs), .i_path(new_path),
    .i_tx_kind(o_tx_kind), .i_tx_tag(o_tx_tag), .o_valid(i_conf_valid), .o_tag(i_conf_tag),
    .o_complete(i_conf_complete), .o_offset(i_conf_offset), .o_path(i_conf_replacement_path_id)
  );
  // ****************************************
  // Shared drivers and checks
  // ****************************************
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
    comparisons++;
    if (got !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", what, e, got);
      bad_count++;
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Every strobe is one cycle; we stop at the falling edge of the answer cycle.
  task automatic go();
    @(posedge i_clk);
    {i_cmd_valid, i_done_valid, i_burst_req, i_frame_valid} <= 4'h0;
    {i_query_valid, i_ua_event, i_wr, i_rd} <= 4'h0;
    @(negedge i_clk);
  endtask
  task automatic cmd(input logic [3:0] t, p, input logic c, w);
    @(posedge i_clk);
    {i_cmd_valid, i_cmd_tag, i_cmd_logical_path_id, i_cmd_confirm, i_cmd_write} <=
      {1'b1, t, p, c, w};
    go();
  endtask
  task automatic eng(input logic d, b, input logic [3:0] t);
    @(posedge i_clk);
    {i_done_valid, i_burst_req, i_done_tag, i_burst_tag} <= {d, b, t, t};
    go();
  endtask
  task automatic frame(input logic [3:0] t, p, input logic drop);
    @(posedge i_clk);
    {i_frame_valid, i_frame_tag, i_frame_logical_path_id} <= {1'b1, t, p};
    go();
    check("frame drop", 32'(drop), 32'(o_frame_drop));
    check("frame accept", 32'(!drop), 32'(o_frame_accept));
  endtask
  task automatic query(input logic d, input logic [3:0] p, input logic [2:0] n);
    @(posedge i_clk);
    {i_query_valid, i_query_direction_bit, i_query_logical_path_id} <= {1'b1, d, p};
    {i_query_init, i_query_port} <= {n, p[0]};
    go();
  endtask
  task automatic ua(input logic m, input logic [2:0] n);
    @(posedge i_clk);
    {i_ua_event, i_ua_by_msg, i_ua_cause_init} <= {1'b1, m, n};
    go();
  endtask
  task automatic bus(input logic w, r, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {i_wr, i_rd, i_addr, i_wdata} <= {w, r, a, d};
    go();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, 1'b1, a, 32'h0);
    check("register read", e, o_rdata);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] e);
    int k;
    k = 0;
    bus(1'b0, 1'b1, a, 32'h0);
    while (o_rdata !== e && k < 16)
    begin
      bus(1'b0, 1'b1, a, 32'h0);
      k++;
    end
    check("register poll", e, o_rdata);
    if (o_rdata !== e)
      test_done();
  endtask
  task automatic wait_tx(input logic [2:0] kind, input int bound, output int n);
    n = 0;
    while (o_tx_kind !== kind && n < bound)
    begin
      @(negedge i_clk);
      n++;
    end
    if (o_tx_kind !== kind)
    begin
      check("message kind", 32'(kind), 32'(o_tx_kind));
      test_done();
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_regs();
    rdc(cst_pkg::REG_STATUS, 32'h0);
    rdc(cst_pkg::REG_UA_FLAGS, 32'h0);
    rdc(8'h20, 32'h0);
    rdc(cst_pkg::REG_PAGE_BASE, 32'(cst_pkg::PAGE_RESET));
    for (int i = 0; i < 16; i++)
      bus(1'b1, 1'b0, cst_pkg::REG_PAGE_BASE + 8'(4 * i), 32'(8'h30 + i));
    for (int i = 15; i >= 0; i--)
      rdc(cst_pkg::REG_PAGE_BASE + 8'(4 * i), 32'(8'h30 + i));
  endtask
  task automatic test_confirm();
    int n;
    cmd(4'h3, 4'h2, 1'b1, 1'b0);
    eng(1'b1, 1'b0, 4'h3);
    wait_tx(cst_pkg::TX_STATUS, 2, n);
    check("status tag", 32'h3, 32'(o_tx_tag));
    poll(cst_pkg::REG_STATUS, 32'h0);
  endtask
  // A slow initiator that lost the status answers only the alert.
  task automatic test_alert();
    int n;
    mode = 2'h1;
    delay = 4'h3;
    cmd(4'h5, 4'h1, 1'b1, 1'b0);
    eng(1'b1, 1'b0, 4'h5);
    wait_tx(cst_pkg::TX_STATUS, 2, n);
    @(negedge i_clk);
    wait_tx(cst_pkg::TX_ALERT, ALERT_C + 4, n);
    check("alert delay", 32'h1, 32'(n >= ALERT_C - 2 && n <= ALERT_C));
    check("alert tag", 32'h5, 32'(o_tx_tag));
    poll(cst_pkg::REG_STATUS, 32'h0);
  endtask
  task automatic test_plain();
    int n;
    cmd(4'h4, 4'h1, 1'b0, 1'b0);
    eng(1'b1, 1'b0, 4'h4);
    wait_tx(cst_pkg::TX_STATUS, 2, n);
    rdc(cst_pkg::REG_STATUS, 32'h0);
    n = 0;
    repeat (2 * ALERT_C)
    begin
      @(negedge i_clk);
      n += int'(o_tx_kind === cst_pkg::TX_ALERT);
    end
    check("alert count", 32'h0, 32'(n));
  endtask
  task automatic test_restart(input logic w);
    int n;
    {mode, new_ofs, new_path} = {2'h2, 32'h0001_2340, 4'h9};
    cmd(4'h6, 4'h1, 1'b1, w);
    eng(1'b1, 1'b0, 4'h6);
    wait_tx(cst_pkg::TX_STATUS, 2, n);
    rdc(cst_pkg::REG_STATUS, 32'h40);
    wait_tx(cst_pkg::TX_ALERT, ALERT_C + 4, n);
    wait_tx(w ? cst_pkg::TX_DATA_REQ : cst_pkg::TX_DATA_RDY, 8, n);
    check("restart offset", new_ofs, o_tx_offset);
    check("restart path", 32'h9, 32'(o_tx_path));
    mode = 2'h0;
    frame(4'h6, 4'h1, 1'b1);
    frame(4'h6, 4'h9, 1'b0);
    eng(1'b1, 1'b0, 4'h6);
    wait_tx(cst_pkg::TX_STATUS, 2, n);
    check("status path", 32'h9, 32'(o_tx_path));
    poll(cst_pkg::REG_STATUS, 32'h0);
  endtask
  task automatic test_hold();
    int n;
    mode = 2'h1;
    @(posedge i_clk);
    i_auto_hold_error_state <= 1'b1;
    cmd(4'h8, 4'h2, 1'b0, 1'b0);
    eng(1'b0, 1'b1, 4'h8);
    check("held grant", 32'h0, 32'(o_burst_grant));
    eng(1'b1, 1'b0, 4'h8);
    check("held status", 32'(cst_pkg::TX_NONE), 32'(o_tx_kind));
    @(posedge i_clk);
    i_auto_hold_error_state <= 1'b0;
    bus(1'b1, 1'b0, cst_pkg::REG_CTRL, 32'h1);
    rdc(cst_pkg::REG_CTRL, 32'h1);
    eng(1'b0, 1'b1, 4'h8);
    check("soft held grant", 32'h0, 32'(o_burst_grant));
    bus(1'b1, 1'b0, cst_pkg::REG_CTRL, 32'h0);
    eng(1'b0, 1'b1, 4'h8);
    check("burst grant", 32'h1, 32'(o_burst_grant));
    eng(1'b1, 1'b0, 4'h8);
    wait_tx(cst_pkg::TX_STATUS, 2, n);
  endtask
  task automatic test_attention();
    query(1'b0, 4'h3, 3'h1);
    query(1'b0, 4'h6, 3'h1);
    query(1'b0, 4'h4, 3'h2);
    query(1'b1, 4'h5, 3'h3);
    ua(1'b1, 3'h2);
    rdc(cst_pkg::REG_UA_FLAGS, 32'h2);
    cmd(4'ha, 4'h6, 1'b0, 1'b0);
    check("check status", 32'(cst_pkg::TX_CHECK), 32'(o_tx_kind));
    check("sense", 32'h1, 32'(o_sense_valid));
    rdc(cst_pkg::REG_UA_FLAGS, 32'h0);
    cmd(4'hb, 4'h3, 1'b0, 1'b0);
    check("sense again", 32'h0, 32'(o_sense_valid));
    ua(1'b0, 3'h0);
    rdc(cst_pkg::REG_UA_FLAGS, 32'h6);
  endtask
  // Free-running clock.
  initial
  begin
    forever #12.5 i_clk = ~i_clk;
  end
  // Reset, then every scenario in turn.
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    test_regs();
    test_confirm();
    test_alert();
    test_plain();
    test_restart(1'b1);
    test_restart(1'b0);
    test_hold();
    test_attention();
    test_done();
  end
endmodule
